//--- common/fdc_status_pkg.sv
// Package with status byte layouts, constants and carrier types
package fdc_status_pkg;

    // Second result byte bit positions
    localparam int TWO_RSVD_BIT      = 7;
    localparam int TWO_CTRL_MARK_BIT = 6;
    localparam int TWO_DATA_CRC_BIT  = 5;
    localparam int TWO_WRONG_TRK_BIT = 4;
    localparam int TWO_SCAN_EQ_BIT   = 3;
    localparam int TWO_SCAN_NS_BIT   = 2;
    localparam int TWO_BAD_TRK_BIT   = 1;
    localparam int TWO_MISS_AM_BIT   = 0;

    // Third result byte bit positions
    localparam int THREE_RSVD7_BIT   = 7;
    localparam int THREE_WPROT_BIT   = 6;
    localparam int THREE_RSVD5_BIT   = 5;
    localparam int THREE_TRK0_BIT    = 4;
    localparam int THREE_RSVD3_BIT   = 3;
    localparam int THREE_HEAD_BIT    = 2;

    // Cross flag positions in bytes zero and one
    localparam int ONE_TRK_FAULT_BIT = 2;
    localparam int ZERO_MISS_AM_BIT  = 0;

    // Reset values and the all-ones track value
    localparam logic [7:0] STATUS_TWO_RESET   = 8'h00;
    localparam logic [7:0] STATUS_THREE_FIXED = 8'h28;
    localparam logic [7:0] TRACK_ALL_ONES     = 8'hFF;

    // Number of bytes in the result phase
    localparam logic [1:0] RESULT_BYTES = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_EXEC   = 2'b01,
        ST_RESULT = 2'b10
    } phase_type;

    // Condition reports from the command engine during execution
    typedef struct packed {
        logic       read_cmd;
        logic       scan_cmd;
        logic       deleted_mark_seen;
        logic       data_crc_err;
        logic       track_check;
        logic [7:0] media_track;
        logic [7:0] cmd_track;
        logic       scan_equal;
        logic       scan_not_met;
        logic       data_am_missing;
        logic       id_am_missing;
    } cond_type;

    // Drive interface levels as seen by the controller
    typedef struct packed {
        logic       wprot_n;
        logic       trk0_n;
        logic       head1_sel_n;
        logic [1:0] drive_sel;
    } drive_type;

    // Compares media track against expected track
    function automatic logic track_differs(input logic [7:0] a, input logic [7:0] b);
        return a != b;
    endfunction

endpackage

//--- core/floppy_result_status_2_3.sv
// Status bytes two and three of the diskette controller result phase
`timescale 1ns/1ps
module floppy_result_status_2_3
    import fdc_status_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       cmd_start,
    input  wire logic       cond_valid,
    input  wire cond_type   cond,
    input  wire logic       cmd_done,
    input  wire drive_type  drv,
    input  wire logic       fifo_rd,
    output logic            fifo_valid,
    output logic [7:0]      fifo_data,
    output logic [7:0]      result_status_two,
    output logic [7:0]      result_status_three,
    output logic            st1_track_fault,
    output logic            st0_mark_missing,
    output logic            result_active
);
    logic [1:0] rst_sync_ff;
    logic       rst_n;
    phase_type  phase_ff;
    logic [7:0] acc_ff;
    logic [7:0] st2_ff;
    logic [7:0] nxt_acc;
    logic       st1_fault_ff;
    logic       st0_miss_ff;
    logic       acc_fault;
    logic       acc_miss;
    logic       nxt_fault;
    logic       nxt_miss;
    logic       rd_done;

    // Reset release synchroniser
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Command phase tracking
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= ST_IDLE;
        end else begin
            case (phase_ff)
                ST_IDLE:   if (cmd_start) phase_ff <= ST_EXEC;
                ST_EXEC:   if (cmd_done) phase_ff <= ST_RESULT;
                ST_RESULT: begin
                    if (cmd_start) begin
                        phase_ff <= ST_EXEC;
                    end else if (rd_done) begin
                        phase_ff <= ST_IDLE;
                    end
                end
                default:   phase_ff <= ST_IDLE;
            endcase
        end
    end

    // Condition accumulation during execution
    always_comb begin
        nxt_acc   = acc_ff;
        nxt_fault = acc_fault;
        nxt_miss  = acc_miss;
        if (cond_valid) begin
            if (cond.read_cmd && cond.deleted_mark_seen) begin
                nxt_acc[TWO_CTRL_MARK_BIT] = 1'b1;
            end
            if (cond.data_crc_err) begin
                nxt_acc[TWO_DATA_CRC_BIT] = 1'b1;
            end
            if (cond.track_check) begin
                if (cond.media_track == TRACK_ALL_ONES &&
                    cond.cmd_track != TRACK_ALL_ONES) begin
                    nxt_acc[TWO_BAD_TRK_BIT] = 1'b1;
                    nxt_fault                = 1'b1;
                end else if (track_differs(cond.media_track, cond.cmd_track)) begin
                    nxt_acc[TWO_WRONG_TRK_BIT] = 1'b1;
                    nxt_fault                  = 1'b1;
                end
            end
            if (cond.scan_cmd && cond.scan_equal) begin
                nxt_acc[TWO_SCAN_EQ_BIT] = 1'b1;
            end
            if (cond.scan_cmd && cond.scan_not_met) begin
                nxt_acc[TWO_SCAN_NS_BIT] = 1'b1;
            end
            if (cond.data_am_missing) begin
                nxt_acc[TWO_MISS_AM_BIT] = 1'b1;
                nxt_miss                 = 1'b1;
            end else if (cond.id_am_missing) begin
                nxt_acc[TWO_MISS_AM_BIT] = 1'b0;
                nxt_miss                 = 1'b1;
            end
        end
        nxt_acc[TWO_RSVD_BIT] = 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff    <= STATUS_TWO_RESET;
            acc_fault <= 1'b0;
            acc_miss  <= 1'b0;
        end else if (cmd_start) begin
            acc_ff    <= STATUS_TWO_RESET;
            acc_fault <= 1'b0;
            acc_miss  <= 1'b0;
        end else if (phase_ff == ST_EXEC) begin
            acc_ff    <= nxt_acc;
            acc_fault <= nxt_fault;
            acc_miss  <= nxt_miss;
        end
    end

    // Capture at completion, held through the result phase
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st2_ff       <= STATUS_TWO_RESET;
            st1_fault_ff <= 1'b0;
            st0_miss_ff  <= 1'b0;
        end else if (phase_ff == ST_EXEC && cmd_done) begin
            st2_ff       <= nxt_acc;
            st1_fault_ff <= nxt_fault;
            st0_miss_ff  <= nxt_miss;
        end
    end

    drive_status_sample u_three (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .sample    (phase_ff == ST_EXEC && cmd_done),
        .drv       (drv),
        .status_ff (result_status_three)
    );

    result_mux u_mux (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .start      (phase_ff == ST_EXEC && cmd_done),
        .rd_strobe  (fifo_rd),
        .byte_two   (nxt_acc),
        .byte_three (result_status_three),
        .rd_valid   (fifo_valid),
        .rd_data_ff (fifo_data),
        .done       (rd_done)
    );

    assign result_status_two = st2_ff;
    assign st1_track_fault   = st1_fault_ff;
    assign st0_mark_missing  = st0_miss_ff;
    assign result_active     = (phase_ff == ST_RESULT);
endmodule // floppy_result_status_2_3

//--- core/result_mux.sv
// Result phase byte sequencer toward the data FIFO
`timescale 1ns/1ps
module result_mux
    import fdc_status_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic       rd_strobe,
    input  wire logic [7:0] byte_two,
    input  wire logic [7:0] byte_three,
    output logic            rd_valid,
    output logic [7:0]      rd_data_ff,
    output logic            done
);
    logic [1:0] idx_ff;
    logic       act_ff;

    assign rd_valid = act_ff;
    assign done     = act_ff && rd_strobe && (idx_ff == RESULT_BYTES - 2'h1);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_ff <= 2'h0;
            act_ff <= 1'b0;
        end else if (start) begin
            idx_ff <= 2'h0;
            act_ff <= 1'b1;
        end else if (done) begin
            act_ff <= 1'b0;
        end else if (act_ff && rd_strobe) begin
            idx_ff <= idx_ff + 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= 8'h00;
        end else if (start) begin
            rd_data_ff <= byte_two;
        end else if (act_ff && rd_strobe) begin
            rd_data_ff <= byte_three;
        end
    end
endmodule // result_mux

//--- core/st3_sample.sv
// Third result byte assembly from drive lines
`timescale 1ns/1ps
module drive_status_sample
    import fdc_status_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       sample,
    input  wire drive_type  drv,
    output logic [7:0]      status_ff
);
    logic [7:0] nxt_status;

    always_comb begin
        nxt_status                  = STATUS_THREE_FIXED;
        nxt_status[THREE_RSVD7_BIT] = 1'b0;
        nxt_status[THREE_WPROT_BIT] = ~drv.wprot_n;
        nxt_status[THREE_TRK0_BIT]  = ~drv.trk0_n;
        nxt_status[THREE_HEAD_BIT]  = ~drv.head1_sel_n;
        nxt_status[1:0]             = drv.drive_sel;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= STATUS_THREE_FIXED;
        end else if (sample) begin
            status_ff <= nxt_status;
        end
    end
endmodule // drive_status_sample

//--- tb/drive_model.sv
// Diskette drive model feeding the controller drive lines
`timescale 1ns/1ps
module drive_model
    import fdc_status_pkg::*;
(
    input  wire logic [1:0] sel,
    input  wire logic [3:0] disk_in,
    input  wire logic       wp,
    input  wire logic       trk0,
    input  wire logic       head1,
    output drive_type       drv,
    output logic            media_n
);
    assign drv.wprot_n     = ~wp;
    assign drv.trk0_n      = ~trk0;
    assign drv.head1_sel_n = ~head1;
    assign drv.drive_sel   = sel;
    // Media level of the selected drive only
    assign media_n = ~disk_in[sel];
endmodule // drive_model

//--- tb/floppy_result_status_2_3_props.sv
// Checker for the result status bytes block
`timescale 1ns/1ps
module floppy_result_status_2_3_props
    import fdc_status_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       arst_n,
    input wire drive_type  drv,
    input wire logic       fifo_rd,
    input wire logic       fifo_valid,
    input wire logic [7:0] fifo_data,
    input wire logic [7:0] result_status_two,
    input wire logic [7:0] result_status_three,
    input wire logic       st1_track_fault,
    input wire logic       st0_mark_missing,
    input wire logic       result_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    AST_TWO_B7: assert property (!result_status_two[7])
        else $error("byte two bit 7 set");
    AST_THREE_FIX: assert property (result_status_three[7:3] ==? 5'b0?1?1)
        else $error("byte three fixed bits wrong");
    AST_FIRST: assert property ($rose(fifo_valid) |-> fifo_data == result_status_two)
        else $error("first result byte wrong");
    AST_SECOND: assert property ($rose(fifo_valid) ##0 fifo_rd |=>
        fifo_valid && fifo_data == result_status_three)
        else $error("second result byte wrong");
    AST_END: assert property (fifo_valid && fifo_rd && !$rose(fifo_valid) |=>
        !fifo_valid && !result_active)
        else $error("result phase not closed");
    AST_HOLD: assert property (result_active |=> $stable(result_status_two))
        else $error("byte two moved in result phase");
    AST_TRK: assert property (
        st1_track_fault == (result_status_two[4] | result_status_two[1]))
        else $error("track fault cross flag wrong");
    AST_MARK: assert property (result_status_two[0] |-> st0_mark_missing)
        else $error("mark cross flag missing");
    AST_DRV: assert property (
        $rose(fifo_valid) |-> result_status_three[6] == !$past(drv.wprot_n)
        && result_status_three[4] == !$past(drv.trk0_n)
        && result_status_three[2] == !$past(drv.head1_sel_n)
        && result_status_three[1:0] == $past(drv.drive_sel))
        else $error("byte three drive bits wrong");
endmodule // floppy_result_status_2_3_props

bind floppy_result_status_2_3 floppy_result_status_2_3_props u_props (.core_clk, .arst_n, .drv,
    .fifo_rd, .fifo_valid, .fifo_data, .result_status_two, .result_status_three,
    .st1_track_fault, .st0_mark_missing, .result_active);

//--- tb/floppy_result_status_2_3_tb_top.sv
// Testbench for the result status bytes block
`timescale 1ns/1ps
module floppy_result_status_2_3_tb_top;
    import fdc_status_pkg::*;
    logic       core_clk = 0, arst_n = 0, cmd_start = 0, cond_valid = 0, cmd_done = 0;
    logic       fifo_rd = 0, fifo_valid, trk_fault, mark_miss, res_act, wp = 0, trk0 = 0;
    logic       head1 = 0, media_n;
    logic [1:0] sel = 0;
    logic [7:0] fifo_data, stat_two, stat_three, e2;
    cond_type   cond = '0;
    drive_type  drv;
    int         n_fail = 0, samples_checked = 0;
    always #12.5 core_clk = ~core_clk;
    drive_model u_drive (.sel, .disk_in(4'h5), .wp, .trk0, .head1, .drv, .media_n);
    floppy_result_status_2_3 u_dut (.core_clk, .arst_n, .cmd_start, .cond_valid, .cond,
        .cmd_done, .drv, .fifo_rd, .fifo_valid, .fifo_data, .result_status_two(stat_two),
        .result_status_three(stat_three), .st1_track_fault(trk_fault),
        .st0_mark_missing(mark_miss), .result_active(res_act));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic pulse_rd();
        fifo_rd = 1;
        @(negedge core_clk);
        fifo_rd = 0;
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(negedge core_clk);
        arst_n = 1;
        repeat (3) @(negedge core_clk);
        check(stat_two, 8'h00);
        check(stat_three, 8'h28);
        // Stray read and completion while idle are ignored
        cmd_done = 1;
        pulse_rd();
        cmd_done = 0;
        check({6'h00, fifo_valid, res_act}, 8'h00);
        for (int i = 0; i < 10; i++) begin
            cond = '0;
            cond.read_cmd = 1;
            e2 = 8'h00;
            case (i)
                0: begin cond.deleted_mark_seen = 1; e2 = 8'h40; end
                1: begin cond.data_crc_err = 1; e2 = 8'h20; end
                2: begin cond.track_check = 1; cond.media_track = 8'h05;
                    cond.cmd_track = 8'h07; e2 = 8'h10; end
                3: begin cond.read_cmd = 0; cond.scan_cmd = 1; cond.scan_equal = 1; e2 = 8'h08; end
                4: begin cond.read_cmd = 0; cond.scan_cmd = 1; cond.scan_not_met = 1; e2 = 8'h04; end
                5: begin cond.track_check = 1; cond.media_track = 8'hFF;
                    cond.cmd_track = 8'h03; e2 = 8'h02; end
                6: begin cond.data_am_missing = 1; e2 = 8'h01; end
                7: cond.id_am_missing = 1;
                8: begin cond.track_check = 1; cond.media_track = 8'hFF; cond.cmd_track = 8'hFF; end
                default: ;
            endcase
            wp = i[0];
            trk0 = i[1];
            head1 = i[2];
            sel = i[1:0];
            cmd_start = 1;
            @(negedge core_clk);
            cmd_start = 0;
            cond_valid = 1;
            @(negedge core_clk);
            cond_valid = 0;
            cmd_done = 1;
            @(negedge core_clk);
            cmd_done = 0;
            check({7'h00, fifo_valid}, 8'h01);
            check(fifo_data, e2);
            check({7'h00, trk_fault}, {7'h00, i == 2 || i == 5});
            check({7'h00, mark_miss}, {7'h00, i == 6 || i == 7});
            check(stat_two, e2);
            check(stat_three, {1'b0, wp, 1'b1, trk0, 1'b1, head1, sel});
            check({7'h00, media_n}, {7'h00, sel[0]});
            pulse_rd();
            check(fifo_data, {1'b0, wp, 1'b1, trk0, 1'b1, head1, sel});
            pulse_rd();
            check({6'h00, fifo_valid, res_act}, 8'h00);
        end
        tally_and_finish();
    end
endmodule // floppy_result_status_2_3_tb_top
